// [hw/gpb_pkg.sv]
// package: register map, reset values and pad carrier for the gpio port block
package gpb_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_W = 8;

  // data register spans offsets 0x000..0x3fc, address bits [9:2] are the mask
  localparam logic [1:0] DATA_REGION_TAG = 2'h0;
  localparam int MASK_LSB = 2;
  localparam int MASK_MSB = 9;
  localparam int REGION_LSB = 10;
  localparam int REGION_MSB = 11;

  localparam logic [ADDR_W-1:0] OFF_DIR = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_SENSE = 12'h404;
  localparam logic [ADDR_W-1:0] OFF_BOTH = 12'h408;
  localparam logic [ADDR_W-1:0] OFF_EVENT = 12'h40C;
  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h410;
  localparam logic [ADDR_W-1:0] OFF_RAW = 12'h414;
  localparam logic [ADDR_W-1:0] OFF_MIS = 12'h418;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h41C;
  localparam logic [ADDR_W-1:0] OFF_ALT = 12'h420;
  localparam logic [ADDR_W-1:0] OFF_DRV_LOW = 12'h500;
  localparam logic [ADDR_W-1:0] OFF_DRV_MID = 12'h504;
  localparam logic [ADDR_W-1:0] OFF_DRV_HIGH = 12'h508;
  localparam logic [ADDR_W-1:0] OFF_OPEN_DRAIN = 12'h50C;
  localparam logic [ADDR_W-1:0] OFF_PULL_UP = 12'h510;
  localparam logic [ADDR_W-1:0] OFF_PULL_DOWN = 12'h514;
  localparam logic [ADDR_W-1:0] OFF_SLEW = 12'h518;
  localparam logic [ADDR_W-1:0] OFF_DIG_EN = 12'h51C;
  localparam logic [ADDR_W-1:0] OFF_LOCK = 12'h520;
  localparam logic [ADDR_W-1:0] OFF_COMMIT = 12'h524;
  // ident words: 0xfd0..0xfec peripheral bytes 0..7, 0xff0..0xffc cell bytes 0..3
  localparam logic [ADDR_W-1:0] OFF_IDENT_BASE = 12'hFD0;
  localparam logic [ADDR_W-1:0] OFF_CELL_BASE = 12'hFF0;

  localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'h5A5A_C3C3;
  localparam logic [PIN_W-1:0] RST_ZERO = 8'h00;
  localparam logic [PIN_W-1:0] RST_DRV_LOW = 8'hFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [PIN_W-1:0] pull_up_select;
    logic [PIN_W-1:0] pull_down_select;
    logic [PIN_W-1:0] drive_low_strength;
    logic [PIN_W-1:0] drive_mid_strength;
    logic [PIN_W-1:0] drive_high_strength;
    logic [PIN_W-1:0] slew_rate_control;
    logic [PIN_W-1:0] open_drain_select;
    logic [PIN_W-1:0] digital_input_enable;
  } gpb_pad_type;
endpackage

// [hw/gpb_port.sv]
// gpio port block: eight pins, masked data, interrupts, commit guard, pad control
// How it works
// - ordinary pins reset undriven; alt select, digital enable, pulls cleared
// - debug pins reset with alt select, digital enable and pull-up set
// - any reset, power-on or external, restores both pin groups' defaults
// - direction 0: pin is input, data bit captures the pin value
// - direction 1: pin is output, data bit drives the pin
// - address bits 9..2 mask the eight data bits on data accesses
// - data register decoded over 256 word addresses, one per mask
// - masked data write changes only bits whose mask bit is one
// - masked data read returns zero where the mask bit is zero
// - all pin interrupts merge into one interrupt output
// - edge interrupt stays latched until software clears it
// - trigger chosen by sense, both-edges and polarity per pin
// - per-pin mask 1 passes interrupt to output, 0 blocks it
// - raw status shows trigger condition regardless of mask
// - masked status is raw status gated by mask
// - writing one to clear location clears latched bit; zero does nothing
// - alt select hands pin to peripheral, else data and direction
// - protected alt select bits written only when unlocked and committed
// - per-pin drive, open drain, pulls, slew and digital enable to pads
// - read-only identification registers fixed at reset
`timescale 1ns/1ns
module gpb_port #(
  parameter logic [7:0] PROTECT_MASK = 8'h80,
  // identification values are arbitrary
  parameter logic [63:0] PERIPH_IDENT = 64'h0000_0000_0000_0061,
  parameter logic [31:0] CELL_IDENT = 32'h0000_0057
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // axi4-lite slave
  input wire logic [gpb_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [gpb_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [gpb_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [gpb_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // package pins
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output gpb_pkg::gpb_pad_type PAD_CTRL,
  // peripheral alternate function
  input wire logic [7:0] ALT_OUT,
  input wire logic [7:0] ALT_OE,
  output logic [7:0] ALT_IN,
  // interrupt
  output logic IRQ
);
  logic [7:0] sync1_reg, sync2_reg, prev_reg;
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [gpb_pkg::ADDR_W-1:0] aw_addr_reg, rd_addr_reg;
  logic [7:0] wd_reg;
  logic wstrb0_reg, wkey_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [7:0] data_reg, dir_reg, sense_reg, both_reg, event_reg, mask_reg, raw_reg;
  logic [7:0] alt_reg, commit_reg;
  logic locked_reg, irq_reg;
  gpb_pkg::gpb_pad_type pad_reg;
  logic wr_go, we;
  logic [7:0] clr_vec, rise, fall, edge_hit, level_hit, raw_next, mis, alt_allow;
  logic [31:0] rd_val;
  logic rd_ok, wr_ok;

  // pins cross into the core clock through two flip-flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_reg <= gpb_pkg::RST_ZERO;
      sync2_reg <= gpb_pkg::RST_ZERO;
      prev_reg <= gpb_pkg::RST_ZERO;
    end else begin
      sync1_reg <= PIN_IN;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ---------------- bus slave ----------------
  assign S_AXI_AWREADY = ~aw_full_reg;
  assign S_AXI_WREADY = ~w_full_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign we = wr_go & wstrb0_reg;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (S_AXI_AWVALID && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= {S_AXI_AWADDR[gpb_pkg::ADDR_W-1:2], 2'h0};
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      w_full_reg <= 1'b0;
      wd_reg <= gpb_pkg::RST_ZERO;
      wstrb0_reg <= 1'b0;
      wkey_reg <= 1'b0;
    end else if (S_AXI_WVALID && !w_full_reg) begin
      w_full_reg <= 1'b1;
      wd_reg <= S_AXI_WDATA[7:0];
      wstrb0_reg <= S_AXI_WSTRB[0];
      // key must arrive as a full word
      wkey_reg <= (S_AXI_WDATA == gpb_pkg::UNLOCK_KEY) && (S_AXI_WSTRB == 4'hF);
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= gpb_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= gpb_pkg::RESP_OKAY;
      rd_addr_reg <= '0;
    end else if (S_AXI_ARVALID && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= rd_ok ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
      rd_addr_reg <= S_AXI_ARADDR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // write address legality; read-only words accept and ignore writes
  always_comb begin
    wr_ok = 1'b1;
    if (aw_addr_reg[gpb_pkg::REGION_MSB:gpb_pkg::REGION_LSB] != gpb_pkg::DATA_REGION_TAG) begin
      unique case (aw_addr_reg)
        gpb_pkg::OFF_DIR, gpb_pkg::OFF_SENSE, gpb_pkg::OFF_BOTH, gpb_pkg::OFF_EVENT,
        gpb_pkg::OFF_MASK, gpb_pkg::OFF_RAW, gpb_pkg::OFF_MIS, gpb_pkg::OFF_CLEAR,
        gpb_pkg::OFF_ALT, gpb_pkg::OFF_DRV_LOW, gpb_pkg::OFF_DRV_MID, gpb_pkg::OFF_DRV_HIGH,
        gpb_pkg::OFF_OPEN_DRAIN, gpb_pkg::OFF_PULL_UP, gpb_pkg::OFF_PULL_DOWN,
        gpb_pkg::OFF_SLEW, gpb_pkg::OFF_DIG_EN, gpb_pkg::OFF_LOCK,
        gpb_pkg::OFF_COMMIT: wr_ok = 1'b1;
        default: wr_ok = aw_addr_reg >= gpb_pkg::OFF_IDENT_BASE;
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    if (S_AXI_ARADDR[gpb_pkg::REGION_MSB:gpb_pkg::REGION_LSB] == gpb_pkg::DATA_REGION_TAG) begin
      rd_val[7:0] = data_reg & S_AXI_ARADDR[gpb_pkg::MASK_MSB:gpb_pkg::MASK_LSB];
    end else if (S_AXI_ARADDR >= gpb_pkg::OFF_CELL_BASE) begin
      rd_val[7:0] = CELL_IDENT[S_AXI_ARADDR[3:2]*8 +: 8];
    end else if (S_AXI_ARADDR >= gpb_pkg::OFF_IDENT_BASE) begin
      rd_val[7:0] = PERIPH_IDENT[3'(S_AXI_ARADDR[4:2] - 3'h4)*8 +: 8];
    end else begin
      unique case ({S_AXI_ARADDR[gpb_pkg::ADDR_W-1:2], 2'h0})
        gpb_pkg::OFF_DIR: rd_val[7:0] = dir_reg;
        gpb_pkg::OFF_SENSE: rd_val[7:0] = sense_reg;
        gpb_pkg::OFF_BOTH: rd_val[7:0] = both_reg;
        gpb_pkg::OFF_EVENT: rd_val[7:0] = event_reg;
        gpb_pkg::OFF_MASK: rd_val[7:0] = mask_reg;
        gpb_pkg::OFF_RAW: rd_val[7:0] = raw_reg;
        gpb_pkg::OFF_MIS: rd_val[7:0] = mis;
        gpb_pkg::OFF_CLEAR: rd_val[7:0] = gpb_pkg::RST_ZERO;
        gpb_pkg::OFF_ALT: rd_val[7:0] = alt_reg;
        gpb_pkg::OFF_DRV_LOW: rd_val[7:0] = pad_reg.drive_low_strength;
        gpb_pkg::OFF_DRV_MID: rd_val[7:0] = pad_reg.drive_mid_strength;
        gpb_pkg::OFF_DRV_HIGH: rd_val[7:0] = pad_reg.drive_high_strength;
        gpb_pkg::OFF_OPEN_DRAIN: rd_val[7:0] = pad_reg.open_drain_select;
        gpb_pkg::OFF_PULL_UP: rd_val[7:0] = pad_reg.pull_up_select;
        gpb_pkg::OFF_PULL_DOWN: rd_val[7:0] = pad_reg.pull_down_select;
        gpb_pkg::OFF_SLEW: rd_val[7:0] = pad_reg.slew_rate_control;
        gpb_pkg::OFF_DIG_EN: rd_val[7:0] = pad_reg.digital_input_enable;
        gpb_pkg::OFF_LOCK: rd_val[0] = locked_reg;
        gpb_pkg::OFF_COMMIT: rd_val[7:0] = commit_reg;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ---------------- data and direction ----------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      data_reg <= gpb_pkg::RST_ZERO;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!dir_reg[i]) begin
          // input pins ignore writes; a disabled input reads as zero
          data_reg[i] <= sync2_reg[i] & pad_reg.digital_input_enable[i];
        end else if (we && aw_addr_reg[gpb_pkg::REGION_MSB:gpb_pkg::REGION_LSB]
                     == gpb_pkg::DATA_REGION_TAG && aw_addr_reg[i+gpb_pkg::MASK_LSB]) begin
          data_reg[i] <= wd_reg[i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir_reg <= gpb_pkg::RST_ZERO;
    end else if (we && aw_addr_reg == gpb_pkg::OFF_DIR) begin
      dir_reg <= wd_reg;
    end
  end

  // ---------------- interrupt logic ----------------
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign edge_hit = (both_reg & (rise | fall))
                  | (~both_reg & ((event_reg & rise) | (~event_reg & fall)));
  assign level_hit = (event_reg & sync2_reg) | (~event_reg & ~sync2_reg);
  assign clr_vec = (we && aw_addr_reg == gpb_pkg::OFF_CLEAR) ? wd_reg : gpb_pkg::RST_ZERO;
  // a new edge in the clear cycle wins over the clear
  assign raw_next = (sense_reg & level_hit)
                  | (~sense_reg & ((raw_reg & ~clr_vec) | edge_hit));
  assign mis = raw_reg & mask_reg;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      raw_reg <= gpb_pkg::RST_ZERO;
      irq_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      irq_reg <= |mis;
    end
  end
  assign IRQ = irq_reg;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sense_reg <= gpb_pkg::RST_ZERO;
      both_reg <= gpb_pkg::RST_ZERO;
      event_reg <= gpb_pkg::RST_ZERO;
      mask_reg <= gpb_pkg::RST_ZERO;
    end else if (we) begin
      // changing triggers while unmasked may raise a spurious event
      if (aw_addr_reg == gpb_pkg::OFF_SENSE) sense_reg <= wd_reg;
      if (aw_addr_reg == gpb_pkg::OFF_BOTH) both_reg <= wd_reg;
      if (aw_addr_reg == gpb_pkg::OFF_EVENT) event_reg <= wd_reg;
      if (aw_addr_reg == gpb_pkg::OFF_MASK) mask_reg <= wd_reg;
    end
  end

  // ---------------- commit protection ----------------
  assign alt_allow = ~PROTECT_MASK | (commit_reg & {8{~locked_reg}});

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      locked_reg <= 1'b1;
      commit_reg <= ~PROTECT_MASK;
    end else if (wr_go && aw_addr_reg == gpb_pkg::OFF_LOCK) begin
      locked_reg <= ~wkey_reg;
    end else if (we && aw_addr_reg == gpb_pkg::OFF_COMMIT && !locked_reg) begin
      commit_reg <= (wd_reg & PROTECT_MASK) | ~PROTECT_MASK;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      alt_reg <= PROTECT_MASK;
    end else if (we && aw_addr_reg == gpb_pkg::OFF_ALT) begin
      alt_reg <= (alt_reg & ~alt_allow) | (wd_reg & alt_allow);
    end
  end

  // ---------------- pad control ----------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pad_reg.pull_up_select <= PROTECT_MASK;
      pad_reg.pull_down_select <= gpb_pkg::RST_ZERO;
      pad_reg.drive_low_strength <= gpb_pkg::RST_DRV_LOW;
      pad_reg.drive_mid_strength <= gpb_pkg::RST_ZERO;
      pad_reg.drive_high_strength <= gpb_pkg::RST_ZERO;
      pad_reg.slew_rate_control <= gpb_pkg::RST_ZERO;
      pad_reg.open_drain_select <= gpb_pkg::RST_ZERO;
      pad_reg.digital_input_enable <= PROTECT_MASK;
    end else if (we) begin
      // drive strengths are exclusive: setting one clears the others
      if (aw_addr_reg == gpb_pkg::OFF_DRV_LOW) begin
        pad_reg.drive_low_strength <= pad_reg.drive_low_strength | wd_reg;
        pad_reg.drive_mid_strength <= pad_reg.drive_mid_strength & ~wd_reg;
        pad_reg.drive_high_strength <= pad_reg.drive_high_strength & ~wd_reg;
      end
      if (aw_addr_reg == gpb_pkg::OFF_DRV_MID) begin
        pad_reg.drive_low_strength <= pad_reg.drive_low_strength & ~wd_reg;
        pad_reg.drive_mid_strength <= pad_reg.drive_mid_strength | wd_reg;
        pad_reg.drive_high_strength <= pad_reg.drive_high_strength & ~wd_reg;
      end
      if (aw_addr_reg == gpb_pkg::OFF_DRV_HIGH) begin
        pad_reg.drive_low_strength <= pad_reg.drive_low_strength & ~wd_reg;
        pad_reg.drive_mid_strength <= pad_reg.drive_mid_strength & ~wd_reg;
        pad_reg.drive_high_strength <= pad_reg.drive_high_strength | wd_reg;
      end
      if (aw_addr_reg == gpb_pkg::OFF_OPEN_DRAIN) pad_reg.open_drain_select <= wd_reg;
      if (aw_addr_reg == gpb_pkg::OFF_PULL_UP) pad_reg.pull_up_select <= wd_reg;
      if (aw_addr_reg == gpb_pkg::OFF_PULL_DOWN) pad_reg.pull_down_select <= wd_reg;
      if (aw_addr_reg == gpb_pkg::OFF_SLEW) pad_reg.slew_rate_control <= wd_reg;
      if (aw_addr_reg == gpb_pkg::OFF_DIG_EN) pad_reg.digital_input_enable <= wd_reg;
    end
  end
  assign PAD_CTRL = pad_reg;

  // ---------------- pin mux ----------------
  logic [7:0] drv_val, drv_en;
  assign drv_val = (alt_reg & ALT_OUT) | (~alt_reg & data_reg);
  assign drv_en = (alt_reg & ALT_OE) | (~alt_reg & dir_reg);
  // open drain only ever pulls low
  assign PIN_OE = drv_en & ~(pad_reg.open_drain_select & drv_val);
  assign PIN_OUT = drv_val & ~pad_reg.open_drain_select;
  assign ALT_IN = sync2_reg;

  // ---------------- assertions ----------------
  a_reset_defaults: assert property (@(posedge CORE_CLK)
    $rose(RESETN) |-> alt_reg == PROTECT_MASK && dir_reg == gpb_pkg::RST_ZERO
      && pad_reg.digital_input_enable == PROTECT_MASK && pad_reg.pull_up_select == PROTECT_MASK
      && pad_reg.pull_down_select == gpb_pkg::RST_ZERO && PIN_OE == (PROTECT_MASK & ALT_OE))
    else $error("configuration not at reset default");

  a_input_capture: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    1 |=> ((data_reg ^ $past(sync2_reg)) & ~$past(dir_reg) & $past(pad_reg.digital_input_enable))
      == gpb_pkg::RST_ZERO)
    else $error("input pin value not captured");

  a_output_drive: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ((dir_reg & ~alt_reg & ~pad_reg.open_drain_select) & ~(PIN_OE & ~(PIN_OUT ^ data_reg)))
      == gpb_pkg::RST_ZERO)
    else $error("output pin not driven from data");

  a_masked_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wr_go |=> ((data_reg ^ $past(data_reg)) & $past(dir_reg)
      & ~$past(aw_addr_reg[gpb_pkg::MASK_MSB:gpb_pkg::MASK_LSB])) == gpb_pkg::RST_ZERO)
    else $error("unmasked data bit changed");

  a_masked_read: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (rvalid_reg && rd_addr_reg[gpb_pkg::REGION_MSB:gpb_pkg::REGION_LSB]
      == gpb_pkg::DATA_REGION_TAG)
      |-> (rdata_reg[7:0] & ~rd_addr_reg[gpb_pkg::MASK_MSB:gpb_pkg::MASK_LSB]) == 8'h00
        && rdata_reg[31:8] == 24'h00_0000)
    else $error("masked read leaked a bit");

  a_edge_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    1 |=> ($past(raw_reg) & ~$past(sense_reg) & ~$past(clr_vec) & ~raw_reg) == gpb_pkg::RST_ZERO)
    else $error("edge status dropped without clear");

  a_clear_one: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    1 |=> ($past(clr_vec) & ~$past(sense_reg) & ~$past(edge_hit) & raw_reg) == gpb_pkg::RST_ZERO)
    else $error("clear did not clear status");

  a_irq_merge: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (raw_reg & mask_reg) != gpb_pkg::RST_ZERO |=> IRQ)
    else $error("interrupt not raised");

  a_mask_block: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (raw_reg & mask_reg) == gpb_pkg::RST_ZERO |=> !IRQ)
    else $error("masked interrupt reached output");

  a_commit_guard: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    locked_reg |=> ((alt_reg ^ $past(alt_reg)) & PROTECT_MASK) == gpb_pkg::RST_ZERO)
    else $error("protected alt bit written while locked");
endmodule

// [testbench/gpb_pin_model.sv]
// pin model: resolves each package pin from port drive, outside driver and pull-up
`timescale 1ns/1ns
module gpb_pin_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_up,
  // outside circuit
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved level
  output logic [7:0] pin_in
);
  logic [7:0] float_reg = 8'h5A;
  logic [7:0] drv;
  // a floating pin must not read as a stable old value
  always @(posedge clk) float_reg <= ~float_reg;
  // outside circuit never pulls bit 7 low while in reset
  assign drv = rst_n ? ext_val : (ext_val | 8'h80);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? drv[i] : pull_up[i] ? 1'b1 : float_reg[i];
    end
  end
endmodule

// [testbench/gpb_port_bench.sv]
// self-checking bench for the gpio port block
`timescale 1ns/1ns
module gpb_port_bench;
  logic clk = 0;
  logic rst_n = 0;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [7:0] pin_in, pin_out, pin_oe, alt_in;
  logic [7:0] alt_out = 0, alt_oe = 0, ev = 0, ee = 0, dreg, m, d;
  gpb_pkg::gpb_pad_type pad;
  int fails = 0, num_checks = 0, cycles = 0;
  always #10 clk = ~clk;
  // identification value is arbitrary
  gpb_port #(.PERIPH_IDENT(64'h1100_0000_0000_0042), .CELL_IDENT(32'h0000_0033)) dut (
    .CORE_CLK(clk), .RESETN(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PAD_CTRL(pad),
    .ALT_OUT(alt_out), .ALT_OE(alt_oe), .ALT_IN(alt_in), .IRQ(irq));
  gpb_pin_model pins (.clk(clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up(pad.pull_up_select), .ext_val(ev), .ext_en(ee), .pin_in(pin_in));
  function automatic logic [7:0] merge(input logic [7:0] old, val, msk);
    return (old & ~msk) | (val & msk);
  endfunction
  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
    while (pa || pw) begin
      @(posedge clk);
      if (awready) pa = 0;
      if (wready) pw = 0;
      if (!pa) awvalid <= 0;
      if (!pw) wvalid <= 0;
    end
    bready <= 1;
    do @(posedge clk); while (!bvalid);
    bready <= 0;
    chk({30'h0, bresp}, 32'h0, "bresp");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    araddr <= a; arvalid <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0; rready <= 1;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    chk(rdata, e, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h2c74_43a3));
    pause(20);
    rst_n <= 1;
    pause(1);
    rd(gpb_pkg::OFF_ALT, 32'h80);
    rd(gpb_pkg::OFF_DIG_EN, 32'h80);
    rd(gpb_pkg::OFF_PULL_UP, 32'h80);
    rd(gpb_pkg::OFF_PULL_DOWN, 32'h0);
    chk({24'h0, pin_oe}, {24'h0, alt_oe[7], 7'h0}, "oe");
    rd(gpb_pkg::OFF_IDENT_BASE, 32'h42);
    rd(12'hFEC, 32'h11);
    rd(gpb_pkg::OFF_CELL_BASE, 32'h33);
    rd(12'h600, 32'h0, gpb_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(gpb_pkg::OFF_DIR, 32'hFF);
    alt_out <= 8'($urandom);
    alt_oe <= 8'($urandom);
    // pin 7 was pulled up and captured while it was still an input
    dreg = 8'h80;
    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      wr({2'h0, m, 2'h0}, {24'h0, d});
      dreg = merge(dreg, d, m);
      m = 8'($urandom);
      rd({2'h0, m, 2'h0}, {24'h0, dreg & m});
    end
    // without byte lane 0 the write must leave the data alone
    wstrb <= 4'h0;
    wr({2'h0, 8'hFF, 2'h0}, {24'h0, ~dreg});
    wstrb <= 4'hF;
    chk({16'h0, pin_oe, pin_out},
      {16'h0, alt_oe[7], 7'h7F, alt_out[7], dreg[6:0]}, "drive");
    wr(gpb_pkg::OFF_OPEN_DRAIN, 32'h01);
    chk({30'h0, pin_oe[0], pin_out[0]}, {30'h0, ~dreg[0], 1'b0}, "drain");
    wr(gpb_pkg::OFF_SLEW, {24'h0, d});
    wr(gpb_pkg::OFF_DRV_HIGH, 32'h01);
    wr(gpb_pkg::OFF_DRV_MID, 32'h02);
    chk({pad.slew_rate_control, pad.drive_low_strength, pad.drive_mid_strength,
      pad.drive_high_strength}, {d, 8'hFC, 8'h02, 8'h01}, "pad");
    $display("test data done");
    wr(gpb_pkg::OFF_DIR, 32'h0);
    wr(gpb_pkg::OFF_DIG_EN, 32'hFF);
    alt_oe <= 0;
    ee <= 8'hFF;
    d = 8'($urandom);
    ev <= d;
    pause(6);
    rd(12'h1FC, {24'h0, d & 8'h7F});
    chk({24'h0, alt_in}, {24'h0, d}, "alt_in");
    // trigger settings change only while masked
    wr(gpb_pkg::OFF_MASK, 32'h0);
    wr(gpb_pkg::OFF_SENSE, 32'h02);
    wr(gpb_pkg::OFF_BOTH, 32'h04);
    wr(gpb_pkg::OFF_EVENT, 32'h01);
    ev <= 0;
    pause(6);
    wr(gpb_pkg::OFF_CLEAR, 32'hFF);
    wr(gpb_pkg::OFF_MASK, 32'h01);
    rd(gpb_pkg::OFF_RAW, 32'h02);
    chk({31'h0, irq}, 32'h0, "irq");
    ev <= 8'h05;
    pause(6);
    rd(gpb_pkg::OFF_RAW, 32'h07);
    rd(gpb_pkg::OFF_MIS, 32'h01);
    chk({31'h0, irq}, 32'h1, "irq");
    wr(gpb_pkg::OFF_CLEAR, 32'h0);
    ev <= 0;
    pause(6);
    ev <= 8'h05;
    pause(6);
    rd(gpb_pkg::OFF_RAW, 32'h07);
    wr(gpb_pkg::OFF_CLEAR, 32'h05);
    rd(gpb_pkg::OFF_RAW, 32'h02);
    rd(gpb_pkg::OFF_MIS, 32'h00);
    chk({31'h0, irq}, 32'h0, "irq");
    $display("test irq done");
    wr(gpb_pkg::OFF_ALT, 32'h0);
    rd(gpb_pkg::OFF_ALT, 32'h80);
    wr(gpb_pkg::OFF_LOCK, gpb_pkg::UNLOCK_KEY);
    wr(gpb_pkg::OFF_COMMIT, 32'h80);
    wr(gpb_pkg::OFF_ALT, 32'h0);
    rd(gpb_pkg::OFF_ALT, 32'h0);
    alt_oe <= 8'h80;
    pause(1);
    chk({31'h0, pin_oe[7]}, 32'h0, "alt");
    $display("test commit done");
    rst_n <= 0;
    pause(2);
    rst_n <= 1;
    pause(1);
    rd(gpb_pkg::OFF_ALT, 32'h80);
    rd(gpb_pkg::OFF_DIR, 32'h0);
    rd(gpb_pkg::OFF_PULL_UP, 32'h80);
    $display("test rereset done");
    complete_run();
  end
endmodule
